// *** hw/xcvr_pkg.sv ***
// Constants shared by the registered octal bus transceiver
package xcvr_pkg;

	// ************************************************************
	// Widths
	// ************************************************************
	localparam int DATA_W = 8;
	localparam int CTRL_SYNC_W = 6;
	localparam int ADDR_W = 8;
	localparam int BUF_DEPTH = 2;

	// ************************************************************
	// Register map
	// ************************************************************
	localparam logic [ADDR_W-1:0] CTRL_OFFSET = 8'h00;
	localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'h04;

	// Control register fields
	localparam int CTRL_DRAIN_HOLD_BIT = 0;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

	// Status register fields
	localparam int STAT_A_STORE_LSB = 0;
	localparam int STAT_B_STORE_LSB = 8;
	localparam int STAT_A_READY_BIT = 16;
	localparam int STAT_B_READY_BIT = 17;
	localparam int STAT_A_PEND_BIT = 18;
	localparam int STAT_B_PEND_BIT = 19;

	// Positions inside the synchronised control vector
	localparam int SYNC_OEN_BIT = 0;
	localparam int SYNC_DIR_BIT = 1;
	localparam int SYNC_SAB_BIT = 2;
	localparam int SYNC_SBA_BIT = 3;
	localparam int SYNC_A_TO_B_CAPTURE_CLOCK_BIT = 4;
	localparam int SYNC_B_TO_A_CAPTURE_CLOCK_BIT = 5;

	// Reset values of driven outputs
	localparam logic [DATA_W-1:0] PORT_OUT_RESET = 8'h00;
	localparam logic [31:0] RD_DATA_RESET = 32'h0000_0000;

endpackage

// *** hw/pin_sync.sv ***
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync #(
	parameter int W = 8
) (
	input wire logic core_clk, // System clock
	input wire logic nrst, // Async reset, active low
	input wire logic [W-1:0] pinIn, // Raw pin levels
	output logic [W-1:0] stable // Filtered levels
);

	logic [W-1:0] stage1_q;
	logic [W-1:0] stage2_q;
	logic [W-1:0] stage3_q;
	logic [W-1:0] stable_q;
	logic [W-1:0] stable_d;

	// Per bit, accept a change only when stages two and three agree
	for (genvar i = 0; i < W; i++) begin : g_bit
		always_comb begin
			stable_d[i] = (stage2_q[i] == stage3_q[i]) ? stage3_q[i] : stable_q[i];
		end
	end

	// Shift chain; stage one feeds stage two only
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			stage1_q <= '0;
			stage2_q <= '0;
			stage3_q <= '0;
			stable_q <= '0;
		end else begin
			stage1_q <= pinIn;
			stage2_q <= stage1_q;
			stage3_q <= stage2_q;
			stable_q <= stable_d;
		end
	end

	assign stable = stable_q;

endmodule

// *** hw/two_entry_buffer.sv ***
// Two-entry valid/ready buffer for captured words
`timescale 1ns/1ps
module two_entry_buffer #(
	parameter int W = 8,
	parameter int DEPTH = 2
) (
	input wire logic core_clk, // System clock
	input wire logic nrst, // Async reset, active low
	input wire logic inValid, // Word offered
	input wire logic [W-1:0] inData, // Offered word
	output logic inReady, // Room for a word
	output logic outValid, // Word waiting
	output logic [W-1:0] outData, // Oldest word
	input wire logic outReady // Drain accepts
);

	localparam int PTR_W = $clog2(DEPTH);

	logic [W-1:0] mem_q [DEPTH];
	logic [W-1:0] mem_d [DEPTH];
	logic [PTR_W-1:0] wrPtr_q, wrPtr_d;
	logic [PTR_W-1:0] rdPtr_q, rdPtr_d;
	logic [PTR_W:0] count_q, count_d;
	logic push;
	logic pop;

	assign inReady = (count_q != (PTR_W+1)'(DEPTH));
	assign outValid = (count_q != '0);
	assign outData = mem_q[rdPtr_q];
	assign push = inValid && inReady;
	assign pop = outValid && outReady;

	// Next pointers, count and storage
	always_comb begin
		mem_d = mem_q;
		wrPtr_d = wrPtr_q;
		rdPtr_d = rdPtr_q;
		count_d = count_q;
		if (push) begin
			mem_d[wrPtr_q] = inData;
			wrPtr_d = (wrPtr_q == PTR_W'(DEPTH-1)) ? '0 : wrPtr_q + 1'b1;
		end
		if (pop) begin
			rdPtr_d = (rdPtr_q == PTR_W'(DEPTH-1)) ? '0 : rdPtr_q + 1'b1;
		end
		if (push && !pop) begin
			count_d = count_q + 1'b1;
		end else if (pop && !push) begin
			count_d = count_q - 1'b1;
		end
	end

	// Pointer and count registers
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count_q <= '0;
		end else begin
			wrPtr_q <= wrPtr_d;
			rdPtr_q <= rdPtr_d;
			count_q <= count_d;
		end
	end

	// Word storage, data only
	always_ff @(posedge core_clk) begin
		mem_q <= mem_d;
	end

endmodule

// *** hw/octal_registered_bus_transceiver.sv ***
// Registered octal bus transceiver with per-direction stores
//
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
module octal_registered_bus_transceiver
	import xcvr_pkg::*;
(
	input wire logic core_clk, // System clock, 100 MHz
	input wire logic nrst, // Async reset, active low
	input wire logic [DATA_W-1:0] portADataIn, // Port A pin level
	output logic [DATA_W-1:0] portADataOut, // Port A drive value
	output logic portADataOe, // Port A driven
	input wire logic [DATA_W-1:0] portBDataIn, // Port B pin level
	output logic [DATA_W-1:0] portBDataOut, // Port B drive value
	output logic portBDataOe, // Port B driven
	input wire logic aToBCaptureClock, // A store clock pin
	input wire logic bToACaptureClock, // B store clock pin
	input wire logic aToBSourceSelect, // B gets store when high
	input wire logic bToASourceSelect, // A gets store when high
	input wire logic outEnableN, // Output enable, active low
	input wire logic direction, // High drives B, low drives A
	input wire logic [ADDR_W-1:0] regAddr, // Register address
	input wire logic [31:0] regWrData, // Register write data
	input wire logic regWrStb, // Write strobe
	input wire logic regRdStb, // Read strobe
	output logic [31:0] regRdData // Read data, next cycle
);

	// ************************************************************
	// Behaviour summary
	// ************************************************************

	// Every outside level except the register port passes the three-stage filter first
	// A level change counts once stages two and three agree
	// Pin to filtered level: four clock edges
	// Filtered level to port drive register: one more edge
	// Drive outputs therefore trail the pins by five edges
	// Live pass-through is a sampled copy, not a wire path
	// Slow live data is fine; glitches shorter than the filter vanish
	//
	// Capture clocks are sampled like any other pin
	// Their high and low phases must each last two cycles or more
	// A rise pushes the filtered data level into a two-entry buffer
	// The buffer drains into the store one word per cycle
	// Storage never looks at enable, direction or selects
	//
	// Drain hold in the control register pauses both stores
	// Up to two rises per side queue while held
	// A third rise on a full side is lost; its ready bit shows this
	// Releasing the hold loads the queued words in order
	//
	// Stores have no reset and read unknown until first capture
	// Drive registers reset to zero with both enables low
	// So nothing is driven while reset is asserted
	//
	// The drive logic picks at most one port at a time
	// Direction low enables A only; direction high enables B only
	// A select reads the store as of the previous cycle
	//
	// Register port answers one cycle after the read strobe
	// Read data return to zero in every other cycle
	// Writes to any address but control are ignored
	// Reads of unmapped addresses return zero
	//
	// A floating data pin is not held; its unknown level reaches the filter output
	// Unknown levels on pins are passed on, not cleaned
	//
	// The two capture clocks are watched independently
	// They need no fixed relation to each other
	// Both may rise in the same cycle; each side has its own buffer

	// ************************************************************
	// Pin synchronisation
	// ************************************************************

	localparam int SYNC_W = 2*DATA_W + CTRL_SYNC_W;

	logic [SYNC_W-1:0] rawPins;
	logic [SYNC_W-1:0] syncPins;
	logic [DATA_W-1:0] aLive;
	logic [DATA_W-1:0] bLive;
	logic oeNSync;
	logic dirSync;
	logic sabSync;
	logic sbaSync;
	logic clkAbSync;
	logic clkBaSync;

	// Gather every outside level except the register port into one filtered vector
	assign rawPins = {portBDataIn, portADataIn, bToACaptureClock, aToBCaptureClock,
		bToASourceSelect, aToBSourceSelect, direction, outEnableN};

	// Agreement filter does not hold a floating line; its unknown level passes through
	pin_sync #(
		.W(SYNC_W)
	) u_pin_sync (
		.core_clk(core_clk),
		.nrst(nrst),
		.pinIn(rawPins),
		.stable(syncPins)
	);

	// Split the filtered vector back into its parts
	assign oeNSync = syncPins[SYNC_OEN_BIT];
	assign dirSync = syncPins[SYNC_DIR_BIT];
	assign sabSync = syncPins[SYNC_SAB_BIT];
	assign sbaSync = syncPins[SYNC_SBA_BIT];
	assign clkAbSync = syncPins[SYNC_A_TO_B_CAPTURE_CLOCK_BIT];
	assign clkBaSync = syncPins[SYNC_B_TO_A_CAPTURE_CLOCK_BIT];
	assign aLive = syncPins[CTRL_SYNC_W +: DATA_W];
	assign bLive = syncPins[CTRL_SYNC_W+DATA_W +: DATA_W];

	// ************************************************************
	// Capture clock edge detection
	// ************************************************************

	logic clkAbPrev_q, clkAbPrev_d;
	logic clkBaPrev_q, clkBaPrev_d;
	logic riseAb;
	logic riseBa;

	// Each clock is watched on its own; the two may be unrelated
	always_comb begin
		clkAbPrev_d = clkAbSync;
		clkBaPrev_d = clkBaSync;
		riseAb = clkAbSync && !clkAbPrev_q;
		riseBa = clkBaSync && !clkBaPrev_q;
	end

	// Previous clock levels
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			clkAbPrev_q <= 1'b0;
			clkBaPrev_q <= 1'b0;
		end else begin
			clkAbPrev_q <= clkAbPrev_d;
			clkBaPrev_q <= clkBaPrev_d;
		end
	end

	// ************************************************************
	// Capture buffers
	// ************************************************************

	logic ctrlDrainHold_q, ctrlDrainHold_d;
	logic aBufReady;
	logic bBufReady;
	logic aBufValid;
	logic bBufValid;
	logic [DATA_W-1:0] aBufData;
	logic [DATA_W-1:0] bBufData;
	logic drainReady;

	// Software may pause the drain; words wait in the buffers
	assign drainReady = !ctrlDrainHold_q;

	// Every A clock rise offers the A level, no output gating
	two_entry_buffer #(
		.W(DATA_W),
		.DEPTH(BUF_DEPTH)
	) u_a_buffer (
		.core_clk(core_clk),
		.nrst(nrst),
		.inValid(riseAb),
		.inData(aLive),
		.inReady(aBufReady),
		.outValid(aBufValid),
		.outData(aBufData),
		.outReady(drainReady)
	);

	// Every B clock rise offers the B level, no output gating
	two_entry_buffer #(
		.W(DATA_W),
		.DEPTH(BUF_DEPTH)
	) u_b_buffer (
		.core_clk(core_clk),
		.nrst(nrst),
		.inValid(riseBa),
		.inData(bLive),
		.inReady(bBufReady),
		.outValid(bBufValid),
		.outData(bBufData),
		.outReady(drainReady)
	);

	// ************************************************************
	// Direction stores
	// ************************************************************

	logic [DATA_W-1:0] storeA_q, storeA_d;
	logic [DATA_W-1:0] storeB_q, storeB_d;

	// Load from the buffer, otherwise hold
	always_comb begin
		storeA_d = storeA_q;
		storeB_d = storeB_q;
		if (aBufValid && drainReady) begin
			storeA_d = aBufData;
		end
		if (bBufValid && drainReady) begin
			storeB_d = bBufData;
		end
	end

	// Stores carry no reset; content unknown until first capture
	always_ff @(posedge core_clk) begin
		storeA_q <= storeA_d;
		storeB_q <= storeB_d;
	end

	// ************************************************************
	// Port drive
	// ************************************************************

	logic [DATA_W-1:0] portAOut_q, portAOut_d;
	logic [DATA_W-1:0] portBOut_q, portBOut_d;
	logic portAOe_q, portAOe_d;
	logic portBOe_q, portBOe_d;

	// Enable and direction pick one port; selects pick live or stored
	always_comb begin
		portAOut_d = portAOut_q;
		portBOut_d = portBOut_q;
		portAOe_d = 1'b0;
		portBOe_d = 1'b0;
		if (!oeNSync) begin
			if (!dirSync) begin
				portAOe_d = 1'b1;
				portAOut_d = sbaSync ? storeB_q : bLive;
			end else begin
				portBOe_d = 1'b1;
				portBOut_d = sabSync ? storeA_q : aLive;
			end
		end
	end

	// Drive registers
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			portAOut_q <= PORT_OUT_RESET;
			portBOut_q <= PORT_OUT_RESET;
			portAOe_q <= 1'b0;
			portBOe_q <= 1'b0;
		end else begin
			portAOut_q <= portAOut_d;
			portBOut_q <= portBOut_d;
			portAOe_q <= portAOe_d;
			portBOe_q <= portBOe_d;
		end
	end

	assign portADataOut = portAOut_q;
	assign portBDataOut = portBOut_q;
	assign portADataOe = portAOe_q;
	assign portBDataOe = portBOe_q;

	// ************************************************************
	// Register port
	// ************************************************************

	logic [31:0] rdData_q, rdData_d;
	logic [31:0] statusWord;

	// Status view of the stores and buffers
	always_comb begin
		statusWord = '0;
		statusWord[STAT_A_STORE_LSB +: DATA_W] = storeA_q;
		statusWord[STAT_B_STORE_LSB +: DATA_W] = storeB_q;
		statusWord[STAT_A_READY_BIT] = aBufReady;
		statusWord[STAT_B_READY_BIT] = bBufReady;
		statusWord[STAT_A_PEND_BIT] = aBufValid;
		statusWord[STAT_B_PEND_BIT] = bBufValid;
	end

	// Write decode and read mux; unmapped reads return zero
	always_comb begin
		ctrlDrainHold_d = ctrlDrainHold_q;
		rdData_d = '0;
		if (regWrStb && (regAddr == CTRL_OFFSET)) begin
			ctrlDrainHold_d = regWrData[CTRL_DRAIN_HOLD_BIT];
		end
		if (regRdStb) begin
			case (regAddr)
				CTRL_OFFSET: begin
					rdData_d[CTRL_DRAIN_HOLD_BIT] = ctrlDrainHold_q;
				end
				STATUS_OFFSET: begin
					rdData_d = statusWord;
				end
				default: begin
					rdData_d = '0;
				end
			endcase
		end
	end

	// Control and read data registers
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			ctrlDrainHold_q <= CTRL_RESET[CTRL_DRAIN_HOLD_BIT];
			rdData_q <= RD_DATA_RESET;
		end else begin
			ctrlDrainHold_q <= ctrlDrainHold_d;
			rdData_q <= rdData_d;
		end
	end

	assign regRdData = rdData_q;

endmodule

// *** tb/bus_agent.sv ***
// Far-side agent and keeper for one data port
`timescale 1ns/1ps
module bus_agent
	import xcvr_pkg::*;
(
	input wire logic drvEn, // Agent drives
	input wire logic [DATA_W-1:0] drvVal, // Agent value
	input wire logic devOe, // Device drives
	input wire logic [DATA_W-1:0] devOut, // Device value
	output logic [DATA_W-1:0] pinLevel // Wire level
);
	logic [DATA_W-1:0] keptQ = 8'h00;
	// Agent yields to the device; a released wire keeps its level
	always_comb begin
		if (devOe) pinLevel = devOut;
		else if (drvEn) pinLevel = drvVal;
		else pinLevel = keptQ;
	end
	always @(pinLevel) keptQ = pinLevel;
endmodule

// *** tb/xcvr_assertions.sv ***
// Port assertions for the registered bus transceiver
`timescale 1ns/1ps
module xcvr_assertions
	import xcvr_pkg::*;
(
	input wire logic core_clk, // Clock
	input wire logic nrst, // Reset
	input wire logic [DATA_W-1:0] portADataIn, // A level
	input wire logic [DATA_W-1:0] portADataOut, // A drive
	input wire logic portADataOe, // A driven
	input wire logic [DATA_W-1:0] portBDataIn, // B level
	input wire logic [DATA_W-1:0] portBDataOut, // B drive
	input wire logic portBDataOe, // B driven
	input wire logic aToBCaptureClock, // A clock
	input wire logic bToACaptureClock, // B clock
	input wire logic aToBSourceSelect, // B source
	input wire logic bToASourceSelect, // A source
	input wire logic outEnableN, // Enable
	input wire logic direction, // Direction
	input wire logic regWrStb // Write strobe
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);
	// ************************************************************
	// Drive control and data paths
	// ************************************************************
	property p_one_side; !(portADataOe && portBDataOe); endproperty
	a_one_side: assert property (p_one_side) else $error("both ports driven");
	property p_isolate; outEnableN [*7] |-> !portADataOe && !portBDataOe; endproperty
	a_isolate: assert property (p_isolate) else $error("port driven while disabled");
	property p_to_a; (!outEnableN && !direction) [*7] |-> portADataOe && !portBDataOe; endproperty
	a_to_a: assert property (p_to_a) else $error("port A not driven");
	property p_to_b; (!outEnableN && direction) [*7] |-> portBDataOe && !portADataOe; endproperty
	a_to_b: assert property (p_to_b) else $error("port B not driven");
	property p_live_a;
		(!outEnableN && !direction && !bToASourceSelect && $stable(portBDataIn)) [*7] |-> portADataOut == portBDataIn;
	endproperty
	a_live_a: assert property (p_live_a) else $error("A does not follow B");
	property p_live_b;
		(!outEnableN && direction && !aToBSourceSelect && $stable(portADataIn)) [*7] |-> portBDataOut == portADataIn;
	endproperty
	a_live_b: assert property (p_live_b) else $error("B does not follow A");
	property p_hold_a;
		(!outEnableN && !direction && bToASourceSelect && !bToACaptureClock && !regWrStb) [*8] |-> $stable(portADataOut);
	endproperty
	a_hold_a: assert property (p_hold_a) else $error("stored B data moved");
	property p_hold_b;
		(!outEnableN && direction && aToBSourceSelect && !aToBCaptureClock && !regWrStb) [*8] |-> $stable(portBDataOut);
	endproperty
	a_hold_b: assert property (p_hold_b) else $error("stored A data moved");
endmodule
bind octal_registered_bus_transceiver xcvr_assertions u_chk (.core_clk(core_clk), .nrst(nrst),
	.portADataIn(portADataIn), .portADataOut(portADataOut), .portADataOe(portADataOe),
	.portBDataIn(portBDataIn), .portBDataOut(portBDataOut), .portBDataOe(portBDataOe),
	.aToBCaptureClock(aToBCaptureClock), .bToACaptureClock(bToACaptureClock),
	.aToBSourceSelect(aToBSourceSelect), .bToASourceSelect(bToASourceSelect),
	.outEnableN(outEnableN), .direction(direction), .regWrStb(regWrStb));

// *** tb/test_octal_registered_bus_transceiver.sv ***
// Random self-checking bench for the registered bus transceiver
`timescale 1ns/1ps
module test_octal_registered_bus_transceiver
	import xcvr_pkg::*;
;
	logic core_clk = 0, nrst = 0, aCk = 0, bCk = 0, a_to_b_source_select = 0, b_to_a_source_select = 0, oeNPin = 1, dirPin = 0;
	logic aEn = 1, bEn = 1, regWrStb = 0, regRdStb = 0, aOe, bOe;
	logic [7:0] aVal = 8'h00, bVal = 8'h00, aLvl, bLvl, aOut, bOut, regAddr = 8'h00;
	logic [31:0] regWrData = 32'h0, regRdData, d, seed = 32'hDCB1;
	logic [7:0] lvlA = 8'h00, lvlB = 8'h00, stA, stB, v1;
	logic oeN, dir, drvA, drvB, wasA = 0, wasB = 0;
	int nMismatch = 0, checkCount = 0;
	always #5 core_clk = ~core_clk;
	octal_registered_bus_transceiver DUT (.core_clk(core_clk), .nrst(nrst), .portADataIn(aLvl),
		.portADataOut(aOut), .portADataOe(aOe), .portBDataIn(bLvl), .portBDataOut(bOut), .portBDataOe(bOe),
		.aToBCaptureClock(aCk), .bToACaptureClock(bCk), .aToBSourceSelect(a_to_b_source_select), .bToASourceSelect(b_to_a_source_select),
		.outEnableN(oeNPin), .direction(dirPin), .regAddr(regAddr), .regWrData(regWrData),
		.regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData));
	bus_agent agentA (.drvEn(aEn), .drvVal(aVal), .devOe(aOe), .devOut(aOut), .pinLevel(aLvl));
	bus_agent agentB (.drvEn(bEn), .drvVal(bVal), .devOe(bOe), .devOut(bOut), .pinLevel(bLvl));
	// ************************************************************
	// Helpers
	// ************************************************************
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [7:0] pick(input logic sel, input logic [7:0] live, input logic [7:0] held);
		return sel ? held : live;
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checkCount++;
		if (seen !== exp) begin
			nMismatch++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge core_clk);
		regAddr <= a;
		regWrData <= v;
		regWrStb <= 1'b1;
		@(posedge core_clk);
		regWrStb <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge core_clk);
		regAddr <= a;
		regRdStb <= 1'b1;
		@(posedge core_clk);
		regRdStb <= 1'b0;
		#1 v = regRdData;
	endtask
	task automatic pulse(input logic ca, input logic cb);
		aCk <= ca;
		bCk <= cb;
		repeat (6) @(posedge core_clk);
		aCk <= 1'b0;
		bCk <= 1'b0;
		repeat (6) @(posedge core_clk);
	endtask
	task automatic tally_and_finish;
		$display("checks=%0d mismatches=%0d", checkCount, nMismatch);
		if (nMismatch == 0 && checkCount > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// Watchdog against a hung run
	initial begin
		#200000;
		nMismatch++;
		tally_and_finish;
	end
	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		repeat (12) @(posedge core_clk);
		nrst <= 1'b1;
		wr(CTRL_OFFSET, 32'h1);
		rd(CTRL_OFFSET, d);
		chk(d, 32'h1);
		rd(8'h08, d);
		chk(d, 32'h0);
		wr(CTRL_OFFSET, 32'h0);
		// Random modes, captures on the undriven side, keeper releases
		for (int i = 0; i < 24; i++) begin
			seed = lfsr(seed);
			oeN = seed[0] | (i == 0);
			dir = seed[1];
			drvA = !oeN && !dir;
			drvB = !oeN && dir;
			aEn <= !(seed[4] && !wasA);
			bEn <= !(seed[5] && !wasB);
			aVal <= seed[15:8];
			bVal <= seed[23:16];
			if (!drvA && !(seed[4] && !wasA)) lvlA = seed[15:8];
			if (!drvB && !(seed[5] && !wasB)) lvlB = seed[23:16];
			oeNPin <= oeN;
			dirPin <= dir;
			a_to_b_source_select <= seed[2];
			b_to_a_source_select <= seed[3];
			repeat (8) @(posedge core_clk);
			pulse(!drvA, !drvB);
			if (!drvA) stA = lvlA;
			if (!drvB) stB = lvlB;
			repeat (8) @(posedge core_clk);
			if (drvA) lvlA = pick(seed[3], lvlB, stB);
			if (drvB) lvlB = pick(seed[2], lvlA, stA);
			chk(aOe, drvA);
			chk(bOe, drvB);
			if (drvA) chk(aOut, lvlA);
			if (drvB) chk(bOut, lvlB);
			rd(STATUS_OFFSET, d);
			chk(d[15:0], {stB, stA});
			wasA = drvA;
			wasB = drvB;
		end
		// Held captures queue two deep, the third is dropped
		oeNPin <= 1'b1;
		aEn <= 1'b1;
		wr(CTRL_OFFSET, 32'h1);
		for (int k = 0; k < 3; k++) begin
			seed = lfsr(seed);
			if (k == 1) v1 = seed[7:0];
			aVal <= seed[7:0];
			repeat (8) @(posedge core_clk);
			pulse(1'b1, 1'b0);
		end
		rd(STATUS_OFFSET, d);
		chk(d[STAT_A_READY_BIT], 1'b0);
		chk(d[7:0], stA);
		wr(CTRL_OFFSET, 32'h0);
		repeat (10) @(posedge core_clk);
		rd(STATUS_OFFSET, d);
		chk(d[7:0], v1);
		tally_and_finish;
	end
endmodule
